/* File: pkg/asmc_pkg.sv */
package asmc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_DEVICE_ID     = 8'h00;
	localparam logic [7:0] OFS_POWER_CTL     = 8'h01;
	localparam logic [7:0] OFS_DIGITAL_CTL   = 8'h02;
	localparam logic [7:0] OFS_ANALOG_CONFIG = 8'h06;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_POWER_CTL     = 8'hfd;
	localparam logic [7:0] RST_DIGITAL_CTL   = 8'h14;
	localparam logic [7:0] RST_ANALOG_CONFIG = 8'h51;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PWR_SHUTDOWN_N_BIT = 0;
	localparam int PWR_SLEEP_BIT      = 1;
	localparam int DIG_FMT_LSB        = 0;
	localparam int DIG_DOUBLE_BIT     = 3;
	localparam int DIG_BOOST_LSB      = 4;
	localparam int ANA_CH_SEL_BIT     = 1;
	localparam int ANA_GAIN_LSB       = 2;
	localparam int ANA_PARALLEL_BRIDGE_MODE_BIT       = 7;

	// ----------------------------------------
	// Audio format codes and fixed values
	// ----------------------------------------
	localparam logic [2:0] FMT_I2S     = 3'h4;
	localparam logic [2:0] FMT_LJ      = 3'h5;
	localparam logic [6:0] BUS_ADDR_HI = 7'h6c;  // 110110x, low bit from pin
	localparam logic [1:0] BOOST_HW    = 2'h1;
	localparam logic [5:0] HALF_32FS   = 6'h10;
	localparam logic [5:0] HALF_48FS   = 6'h18;
	localparam logic [5:0] HALF_64FS   = 6'h20;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int SYS_CLK_HZ    = 10_000_000;
	localparam int DS_MIN_FS_HZ  = 64_000;   // Split between the two speed bands
	localparam int DS_LIMIT_CYC  = SYS_CLK_HZ / DS_MIN_FS_HZ;
	localparam int MIN_FS_HZ     = 8_000;    // Slower frames mean clocks stopped
	localparam int FRAME_TO_CYC  = SYS_CLK_HZ / MIN_FS_HZ;

endpackage

/* File: pkg/asmc_reg_if.sv */
`timescale 1ns/100ps
// Register access between the bus slave and the register file
interface asmc_reg_if;
	logic       wr_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport port (output wr_stb, output addr, output wdata, input rdata);
	modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface

/* File: rtl/asmc_i2c_slave.sv */
`timescale 1ns/100ps
module asmc_i2c_slave
	import asmc_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	input  wire logic enable_i,
	input  wire logic [6:0] dev_addr_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_drive_n_o,
	asmc_reg_if.port  bus
);

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK, S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
	} asmc_i2c_state_e;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] scl_sync_r, sda_sync_r;
	logic       scl_old_r, sda_old_r;

	// Edge detection reads only the second stage
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_old_r  <= 1'b1;
			sda_old_r  <= 1'b1;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[0], scl_i};
			sda_sync_r <= {sda_sync_r[0], sda_i};
			scl_old_r  <= scl_sync_r[1];
			sda_old_r  <= sda_sync_r[1];
		end
	end

	wire scl_rise = scl_sync_r[1] & ~scl_old_r;
	wire scl_fall = ~scl_sync_r[1] & scl_old_r;
	wire start_c  = scl_sync_r[1] & scl_old_r & sda_old_r & ~sda_sync_r[1];
	wire stop_c   = scl_sync_r[1] & scl_old_r & ~sda_old_r & sda_sync_r[1];

	// ----------------------------------------
	// Protocol engine
	// ----------------------------------------
	asmc_i2c_state_e state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt;
	logic [3:0] cnt_r, cnt_nxt;  // Counts to eight, so zero only means no bit yet
	logic       rd_r, rd_nxt, drv_n_r, drv_n_nxt, stb_r, stb_nxt;

	// Slave only, never stretches the clock
	always_comb
	begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		ptr_nxt   = ptr_r;
		cnt_nxt   = cnt_r;
		rd_nxt    = rd_r;
		drv_n_nxt = drv_n_r;
		stb_nxt   = 1'b0;
		if (!enable_i || stop_c)
		begin
			state_nxt = S_IDLE;
			drv_n_nxt = 1'b1;
		end
		else if (start_c)
		begin
			state_nxt = S_ADDR;
			cnt_nxt   = 4'h0;
			drv_n_nxt = 1'b1;
		end
		else if (scl_rise)
		begin
			unique case (state_r)
				S_ADDR, S_REG, S_WDATA:
				begin
					shift_nxt = {shift_r[6:0], sda_sync_r[1]};
					cnt_nxt   = cnt_r + 4'h1;
				end
				S_RDATA_ACK: rd_nxt = ~sda_sync_r[1];               // Master ack keeps reading
				default: ;
			endcase
		end
		else if (scl_fall)
		begin
			unique case (state_r)
				S_IDLE: ;
				S_ADDR:
					if (cnt_r == 4'h8)
					begin
						// Address in upper seven bits, direction in bit 0
						if (shift_r[7:1] == dev_addr_i)
						begin
							state_nxt = S_ADDR_ACK;
							rd_nxt    = shift_r[0];
							drv_n_nxt = 1'b0;
						end
						else
							state_nxt = S_IDLE;
					end
				S_REG, S_WDATA:
					if (cnt_r == 4'h8)
					begin
						state_nxt = (state_r == S_REG) ? S_REG_ACK : S_WDATA_ACK;
						drv_n_nxt = 1'b0;
						if (state_r == S_REG)
							ptr_nxt = shift_r;
						else
							stb_nxt = 1'b1;
					end
				S_ADDR_ACK, S_REG_ACK, S_WDATA_ACK, S_RDATA_ACK:
				begin
					cnt_nxt   = 4'h0;
					drv_n_nxt = 1'b1;
					if (state_r == S_WDATA_ACK)
						ptr_nxt = ptr_r + 8'h01;
					if ((state_r == S_ADDR_ACK && rd_r) || (state_r == S_RDATA_ACK && rd_r))
					begin
						state_nxt = S_RDATA;
						shift_nxt = bus.rdata;
						drv_n_nxt = bus.rdata[7];
					end
					else if (state_r == S_RDATA_ACK)
						state_nxt = S_IDLE;                              // Nack ends the read
					else
						state_nxt = (state_r == S_ADDR_ACK) ? S_REG : S_WDATA;
				end
				S_RDATA:
				begin
					cnt_nxt = cnt_r + 4'h1;
					if (cnt_r == 4'h7)
					begin
						state_nxt = S_RDATA_ACK;
						drv_n_nxt = 1'b1;
						ptr_nxt   = ptr_r + 8'h01;
					end
					else
					begin
						shift_nxt = {shift_r[6:0], 1'b0};
						drv_n_nxt = shift_r[6];
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_r <= S_IDLE;
			shift_r <= 8'h00;
			ptr_r   <= 8'h00;
			cnt_r   <= 4'h0;
			rd_r    <= 1'b0;
			drv_n_r <= 1'b1;
			stb_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			ptr_r   <= ptr_nxt;
			cnt_r   <= cnt_nxt;
			rd_r    <= rd_nxt;
			drv_n_r <= drv_n_nxt;
			stb_r   <= stb_nxt;
		end
	end

	// Write data stays in shift_r until the first rising clock edge of the next byte
	assign bus.wr_stb    = stb_r;
	assign bus.addr      = ptr_r;
	assign bus.wdata     = shift_r;
	assign sda_drive_n_o = drv_n_r;

endmodule

/* File: rtl/asmc_top.sv */
`timescale 1ns/100ps
module asmc_top
	import asmc_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID = 8'h00   // Arbitrary value
)
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        bit_clk_i,
	input  wire logic        lr_clk_i,
	input  wire logic        serial_audio_in_i,
	input  wire logic [1:0]  gain_sel_i,
	input  wire logic        amp_shutdown_n_i,
	input  wire logic        sleep_addr_select_i,
	input  wire logic        bridge_sel_or_bus_clock_i,
	input  wire logic        freq_sel_or_bus_data_i,
	output logic             freq_sel_or_bus_data_o,
	output logic             freq_sel_or_bus_data_drive_n_o,
	output logic             amp_enable_o,
	output logic             amp_sleep_o,
	output logic             parallel_bridge_mode_o,
	output logic [1:0]       analog_gain_o,
	output logic [1:0]       digital_boost_o,
	output logic             double_speed_o,
	output logic             clock_error_o,
	output logic [15:0]      audio_left_o,
	output logic [15:0]      audio_right_o,
	output logic             audio_valid_o
);

	// ----------------------------------------
	// Pin synchronisers, system domain
	// ----------------------------------------
	logic [1:0] gain0_s_r, gain1_s_r, sd_n_s_r, sleep_s_r, parallel_bridge_mode_s_r, tgl_s_r;
	logic       tgl_old_r, frame_tgl_r;

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			gain0_s_r <= 2'h0;
			gain1_s_r <= 2'h0;
			sd_n_s_r  <= 2'h0;
			sleep_s_r <= 2'h0;
			parallel_bridge_mode_s_r  <= 2'h0;
			tgl_s_r   <= 2'h0;
			tgl_old_r <= 1'b0;
		end
		else
		begin
			gain0_s_r <= {gain0_s_r[0], gain_sel_i[0]};
			gain1_s_r <= {gain1_s_r[0], gain_sel_i[1]};
			sd_n_s_r  <= {sd_n_s_r[0], amp_shutdown_n_i};
			sleep_s_r <= {sleep_s_r[0], sleep_addr_select_i};
			parallel_bridge_mode_s_r  <= {parallel_bridge_mode_s_r[0], bridge_sel_or_bus_clock_i};
			tgl_s_r   <= {tgl_s_r[0], frame_tgl_r};
			tgl_old_r <= tgl_s_r[1];
		end
	end

	// Both gain pins high hands the shared pins to the control port
	wire sw_mode = gain0_s_r[1] & gain1_s_r[1];
	wire frame_c = tgl_s_r[1] ^ tgl_old_r;

	// ----------------------------------------
	// Address strap capture
	// ----------------------------------------
	logic [1:0] strap_cnt_r, strap_cnt_nxt;
	logic       addr_lsb_r, addr_lsb_nxt;

	// Waits for the synchroniser to fill, then holds the strap for good
	always_comb
	begin
		strap_cnt_nxt = strap_cnt_r;
		addr_lsb_nxt  = addr_lsb_r;
		if (strap_cnt_r != 2'h3)
		begin
			strap_cnt_nxt = strap_cnt_r + 2'h1;
			if (strap_cnt_r == 2'h2)
				addr_lsb_nxt = sleep_s_r[1];
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			strap_cnt_r <= 2'h0;
			addr_lsb_r  <= 1'b0;
		end
		else
		begin
			strap_cnt_r <= strap_cnt_nxt;
			addr_lsb_r  <= addr_lsb_nxt;
		end
	end

	// ----------------------------------------
	// Control port and register file
	// ----------------------------------------
	asmc_reg_if reg_bus ();
	logic       sda_drive_n;

	asmc_i2c_slave u_i2c (
		.sys_clk_i     (sys_clk_i),
		.reset_i       (reset_i),
		.enable_i      (sw_mode && strap_cnt_r == 2'h3),
		.dev_addr_i    ({BUS_ADDR_HI[6:1], addr_lsb_r}),
		.scl_i         (bridge_sel_or_bus_clock_i),
		.sda_i         (freq_sel_or_bus_data_i),
		.sda_drive_n_o (sda_drive_n),
		.bus           (reg_bus.port)
	);

	logic [7:0] power_ctl_r, power_ctl_nxt, digital_ctl_r, digital_ctl_nxt;
	logic [7:0] analog_cfg_r, analog_cfg_nxt;

	// Unlisted offsets ignore writes and read as zero
	always_comb
	begin
		power_ctl_nxt  = power_ctl_r;
		digital_ctl_nxt = digital_ctl_r;
		analog_cfg_nxt = analog_cfg_r;
		if (reg_bus.wr_stb)
		begin
			unique case (reg_bus.addr)
				OFS_POWER_CTL:     power_ctl_nxt   = reg_bus.wdata;
				OFS_DIGITAL_CTL:   digital_ctl_nxt = reg_bus.wdata;
				OFS_ANALOG_CONFIG: analog_cfg_nxt  = reg_bus.wdata;
				default: ;
			endcase
		end
		unique case (reg_bus.addr)
			OFS_DEVICE_ID:     reg_bus.rdata = DEVICE_ID;
			OFS_POWER_CTL:     reg_bus.rdata = power_ctl_r;
			OFS_DIGITAL_CTL:   reg_bus.rdata = digital_ctl_r;
			OFS_ANALOG_CONFIG: reg_bus.rdata = analog_cfg_r;
			default:           reg_bus.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			power_ctl_r   <= RST_POWER_CTL;
			digital_ctl_r <= RST_DIGITAL_CTL;
			analog_cfg_r  <= RST_ANALOG_CONFIG;
		end
		else
		begin
			power_ctl_r   <= power_ctl_nxt;
			digital_ctl_r <= digital_ctl_nxt;
			analog_cfg_r  <= analog_cfg_nxt;
		end
	end

	// ----------------------------------------
	// Link domain: bit clock capture
	// ----------------------------------------
	logic [1:0]  lrst_r, fmt0_s_r, fmt1_s_r, fmt2_s_r;
	logic        lr_r, lr_old_r, sd_r;
	logic [31:0] shift_r;
	logic [5:0]  bits_r, half_hold_r;
	logic [15:0] left_hold_r, right_hold_r, left_tmp_r;

	// Reset asserts at once and releases on the bit clock
	always_ff @(posedge bit_clk_i or posedge reset_i)
	begin
		if (reset_i)
			lrst_r <= 2'h3;
		else
			lrst_r <= {lrst_r[0], 1'b0};
	end

	// Chooses the 16-bit word out of the half frame just ended
	function automatic logic [15:0] asmc_word(input logic [31:0] sh, input logic [5:0] n,
		input logic [2:0] fmt);
		logic [5:0] skip;
		skip = 6'h00;
		if (fmt == FMT_LJ && n > 6'h10)
			skip = n - 6'h10;
		else if (fmt == FMT_I2S && n > 6'h11)
			skip = n - 6'h11;                                       // One bit late after the edge
		return 16'(sh >> skip);
	endfunction

	wire [2:0] fmt_l = {fmt2_s_r[1], fmt1_s_r[1], fmt0_s_r[1]};

	// Format is static in use, so a level crossing per bit is safe
	always_ff @(posedge bit_clk_i or posedge lrst_r[1])
	begin
		if (lrst_r[1])
		begin
			fmt0_s_r     <= 2'h0;
			fmt1_s_r     <= 2'h0;
			fmt2_s_r     <= 2'h0;
			lr_r         <= 1'b0;
			lr_old_r     <= 1'b0;
			sd_r         <= 1'b0;
			shift_r      <= 32'h0000_0000;
			bits_r       <= 6'h00;
			half_hold_r  <= 6'h00;
			left_tmp_r   <= 16'h0000;
			left_hold_r  <= 16'h0000;
			right_hold_r <= 16'h0000;
			frame_tgl_r  <= 1'b0;
		end
		else
		begin
			fmt0_s_r <= {fmt0_s_r[0], digital_ctl_r[DIG_FMT_LSB]};
			fmt1_s_r <= {fmt1_s_r[0], digital_ctl_r[DIG_FMT_LSB + 1]};
			fmt2_s_r <= {fmt2_s_r[0], digital_ctl_r[DIG_FMT_LSB + 2]};
			lr_r     <= lr_clk_i;
			sd_r     <= serial_audio_in_i;
			lr_old_r <= lr_r;
			shift_r  <= {shift_r[30:0], sd_r};
			if (lr_r != lr_old_r)
			begin
				bits_r <= 6'h01;
				if (!lr_old_r)
					left_tmp_r <= asmc_word(shift_r, bits_r, fmt_l);
				else
				begin
					// Right half closes the frame; holds stay put a whole frame
					left_hold_r  <= left_tmp_r;
					right_hold_r <= asmc_word(shift_r, bits_r, fmt_l);
					half_hold_r  <= bits_r;
					frame_tgl_r  <= ~frame_tgl_r;
				end
			end
			else if (bits_r != 6'h3f)
				bits_r <= bits_r + 6'h01;
		end
	end

	// ----------------------------------------
	// Clock checks and outputs
	// ----------------------------------------
	logic [12:0] period_r, period_nxt;
	logic        clk_err_r, clk_err_nxt, valid_nxt, enable_nxt;
	logic [15:0] left_nxt, right_nxt;

	wire ds_sel   = sw_mode & digital_ctl_r[DIG_DOUBLE_BIT];
	wire parallel_bridge_mode_sel = sw_mode ? analog_cfg_r[ANA_PARALLEL_BRIDGE_MODE_BIT] : parallel_bridge_mode_s_r[1];
	wire half_ok  = half_hold_r == HALF_32FS || half_hold_r == HALF_48FS
		|| half_hold_r == HALF_64FS;

	// Frame period in system cycles tells single from double speed
	always_comb
	begin
		period_nxt  = (period_r == 13'(FRAME_TO_CYC)) ? period_r : period_r + 13'h0001;
		clk_err_nxt = clk_err_r;
		valid_nxt   = 1'b0;
		left_nxt    = audio_left_o;
		right_nxt   = audio_right_o;
		if (period_r == 13'(FRAME_TO_CYC))
			clk_err_nxt = 1'b1;                                     // Clocks have stopped
		if (frame_c)
		begin
			period_nxt  = 13'h0000;
			// Bit clock ratio and speed band must agree with the mode
			clk_err_nxt = !half_ok
				|| (ds_sel != (period_r < 13'(DS_LIMIT_CYC)));
			valid_nxt   = !clk_err_nxt;
			left_nxt    = left_hold_r;
			right_nxt   = right_hold_r;
			if (parallel_bridge_mode_sel)
			begin
				// Both output channels carry the selected input
				left_nxt  = analog_cfg_r[ANA_CH_SEL_BIT] ? right_hold_r : left_hold_r;
				right_nxt = left_nxt;
			end
		end
		// Shutdown pin rules in both modes; register bit only in software mode
		enable_nxt = sd_n_s_r[1] && !clk_err_nxt
			&& (!sw_mode || power_ctl_r[PWR_SHUTDOWN_N_BIT]);
		// Quiet at once, also when the clocks stop and no frame arrives
		if (clk_err_nxt || !enable_nxt)
		begin
			left_nxt  = 16'h0000;
			right_nxt = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			period_r                       <= 13'h0000;
			clk_err_r                      <= 1'b1;
			audio_valid_o                  <= 1'b0;
			audio_left_o                   <= 16'h0000;
			audio_right_o                  <= 16'h0000;
			amp_enable_o                   <= 1'b0;
			amp_sleep_o                    <= 1'b0;
			parallel_bridge_mode_o         <= 1'b0;
			analog_gain_o                  <= 2'h0;
			digital_boost_o                <= BOOST_HW;
			double_speed_o                 <= 1'b0;
			freq_sel_or_bus_data_drive_n_o <= 1'b1;
			freq_sel_or_bus_data_o         <= 1'b0;
		end
		else
		begin
			period_r               <= period_nxt;
			clk_err_r              <= clk_err_nxt;
			audio_valid_o          <= valid_nxt;
			audio_left_o           <= left_nxt;
			audio_right_o          <= right_nxt;
			amp_enable_o           <= enable_nxt;
			amp_sleep_o            <= sleep_s_r[1] | (sw_mode & power_ctl_r[PWR_SLEEP_BIT]);
			parallel_bridge_mode_o <= parallel_bridge_mode_sel;
			// Software gain comes straight from the register field
			analog_gain_o          <= sw_mode ? analog_cfg_r[ANA_GAIN_LSB +: 2]
				: {gain1_s_r[1], gain0_s_r[1]};
			digital_boost_o        <= sw_mode ? digital_ctl_r[DIG_BOOST_LSB +: 2] : BOOST_HW;
			double_speed_o         <= ds_sel;
			// Open drain: only ever pulls low
			freq_sel_or_bus_data_drive_n_o <= sda_drive_n;
			freq_sel_or_bus_data_o <= 1'b0;
		end
	end

	assign clock_error_o = clk_err_r;

endmodule

/* File: testbench/asmc_sva.sv */
`timescale 1ns/100ps
module asmc_chk
	import asmc_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic [1:0]  gain_sel_i,
	input  wire logic        amp_shutdown_n_i,
	input  wire logic        sleep_addr_select_i,
	input  wire logic        bridge_sel_or_bus_clock_i,
	input  wire logic        amp_enable_o,
	input  wire logic        amp_sleep_o,
	input  wire logic        parallel_bridge_mode_o,
	input  wire logic [1:0]  analog_gain_o,
	input  wire logic [1:0]  digital_boost_o,
	input  wire logic        double_speed_o,
	input  wire logic        clock_error_o,
	input  wire logic [15:0] audio_left_o,
	input  wire logic [15:0] audio_right_o,
	input  wire logic        audio_valid_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	// ----------------------------------------
	// Pin and mode relations; five or six cycles cover the pin synchronisers
	// ----------------------------------------
	property p_shutdown;
		!amp_shutdown_n_i [*5] |-> !amp_enable_o;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("amp on in shutdown");
	property p_sleep;
		sleep_addr_select_i [*5] |-> amp_sleep_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep pin ignored");
	property p_err_quiet;
		clock_error_o [*3] |-> !amp_enable_o && audio_left_o == 16'h0 && audio_right_o == 16'h0;
	endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("output live on clock error");
	property p_valid;
		audio_valid_o |=> !audio_valid_o;
	endproperty
	a_valid: assert property (p_valid) else $error("valid longer than one cycle");
	property p_ds_hw;
		(gain_sel_i != 2'b11) [*6] |-> !double_speed_o;
	endproperty
	a_ds_hw: assert property (p_ds_hw) else $error("double speed in hardware mode");
	property p_boost_hw;
		(gain_sel_i != 2'b11) [*6] |-> digital_boost_o == BOOST_HW;
	endproperty
	a_boost_hw: assert property (p_boost_hw) else $error("hardware boost wrong");
	property p_gain_hw;
		($stable(gain_sel_i) && gain_sel_i != 2'b11) [*6] |-> analog_gain_o == gain_sel_i;
	endproperty
	a_gain_hw: assert property (p_gain_hw) else $error("hardware gain wrong");
	property p_parallel_bridge_mode_hw;
		(gain_sel_i != 2'b11 && $stable(bridge_sel_or_bus_clock_i)) [*6]
			|-> parallel_bridge_mode_o == bridge_sel_or_bus_clock_i;
	endproperty
	a_parallel_bridge_mode_hw: assert property (p_parallel_bridge_mode_hw) else $error("bridge pin ignored");
	c_frame: cover property (audio_valid_o && !clock_error_o);
	c_parallel_bridge_mode: cover property ($rose(parallel_bridge_mode_o));
	c_err: cover property ($fell(clock_error_o));
endmodule

bind asmc_top asmc_chk u_chk
(
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .gain_sel_i(gain_sel_i),
	.amp_shutdown_n_i(amp_shutdown_n_i), .sleep_addr_select_i(sleep_addr_select_i),
	.bridge_sel_or_bus_clock_i(bridge_sel_or_bus_clock_i), .amp_enable_o(amp_enable_o),
	.amp_sleep_o(amp_sleep_o), .parallel_bridge_mode_o(parallel_bridge_mode_o),
	.analog_gain_o(analog_gain_o), .digital_boost_o(digital_boost_o),
	.double_speed_o(double_speed_o), .clock_error_o(clock_error_o),
	.audio_left_o(audio_left_o), .audio_right_o(audio_right_o), .audio_valid_o(audio_valid_o)
);

/* File: testbench/asmc_partner.sv */
`timescale 1ns/100ps
module asmc_partner
(
	input  wire logic sys_clk_i,
	input  wire logic sda_i,
	output logic      scl_o     = 1'b1,
	output logic      sda_o     = 1'b1,
	output logic      bit_clk_o = 1'b0,
	output logic      lr_clk_o  = 1'b0,
	output logic      data_o    = 1'b0
);
	logic        i2s = 1'b1;
	int          gap = 0;
	int          nb  = 32;
	logic [31:0] lw  = 32'hc3a5_5a0f;
	logic [31:0] rw  = 32'h1e87_96b4;
	logic [31:0] w;
	logic [31:0] pw;

	// Audio source; bit clock parked low between frames, I2S one bit late
	always
	begin
		#7;
		for (int h = 0; h < 2; h++)
		begin
			w = h ? rw : lw;
			pw = h ? lw : rw;
			for (int t = 0; t < nb; t++)
			begin
				bit_clk_o = 1'b0;
				lr_clk_o = h[0];
				data_o = i2s ? (t == 0 ? pw[32 - nb] : w[32 - t]) : w[31 - t];
				#24;
				bit_clk_o = 1'b1;
				#24;
			end
		end
		bit_clk_o = 1'b0;
		data_o = ~data_o;
		#(gap);
	end

	// I2C host at 400 kHz; SDA sampled mid-high so a late ack has settled
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic bx(input logic b, output logic r);
		sda_o = b;
		cyc(6);
		scl_o = 1'b1;
		cyc(7);
		r = sda_i;
		cyc(6);
		scl_o = 1'b0;
		cyc(6);
	endtask
	task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic n);
		for (int i = 7; i >= 0; i--)
			bx(d[i], q[i]);
		bx(1'b1, n);
	endtask
	task automatic start();
		sda_o = 1'b1;
		cyc(6);
		scl_o = 1'b1;
		cyc(6);
		sda_o = 1'b0;
		cyc(6);
		scl_o = 1'b0;
		cyc(6);
	endtask
	task automatic acc(input logic [6:0] a, input logic r, input logic [7:0] o,
		input logic [7:0] d, output logic [7:0] q, output logic [3:0] nk);
		nk[3] = 1'b0;
		start();
		xb({a, 1'b0}, q, nk[0]);
		xb(o, q, nk[1]);
		if (r)
		begin
			start();
			xb({a, 1'b1}, q, nk[2]);
			xb(8'hff, q, nk[3]);
		end
		else
			xb(d, q, nk[2]);
		sda_o = 1'b0;
		cyc(6);
		scl_o = 1'b1;
		cyc(6);
		sda_o = 1'b1;
		cyc(6);
	endtask
endmodule

/* File: testbench/tb_amp_software_mode_control.sv */
`timescale 1ns/100ps
module tb_amp_software_mode_control
	import asmc_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sdn = 1'b1;
	logic        slp_i = 1'b1;
	logic [1:0]  gs = 2'h3;
	wire         scl, sdh, bclk, lrc, sd, fo, dn, en, slp, pb, ds, err, vld;
	wire  [1:0]  ag, bst;
	wire  [15:0] al, ar;
	wire         sda = sdh & (dn | fo);
	logic [7:0]  q;
	logic [3:0]  nk;
	logic [2:0]  fm [3] = '{FMT_I2S, FMT_LJ, 3'h0};
	int          n_mismatch = 0;
	int          compares = 0;

	always #50 clk = ~clk;

	asmc_top dut
	(
		.sys_clk_i(clk), .reset_i(rst), .bit_clk_i(bclk), .lr_clk_i(lrc),
		.serial_audio_in_i(sd), .gain_sel_i(gs), .amp_shutdown_n_i(sdn),
		.sleep_addr_select_i(slp_i), .bridge_sel_or_bus_clock_i(scl),
		.freq_sel_or_bus_data_i(sda), .freq_sel_or_bus_data_o(fo),
		.freq_sel_or_bus_data_drive_n_o(dn), .amp_enable_o(en), .amp_sleep_o(slp),
		.parallel_bridge_mode_o(pb), .analog_gain_o(ag), .digital_boost_o(bst),
		.double_speed_o(ds), .clock_error_o(err), .audio_left_o(al),
		.audio_right_o(ar), .audio_valid_o(vld)
	);
	asmc_partner u_host
	(
		.sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sdh),
		.bit_clk_o(bclk), .lr_clk_o(lrc), .data_o(sd)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	// Bounded wait for n accepted frames
	task automatic wv(int n);
		for (int k = 0; k < 4000 && n > 0; k++)
		begin
			@(negedge clk);
			if (vld === 1'b1)
				n--;
		end
		chk("frames", 16'h0, 16'(n));
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		u_host.acc(7'h6d, 1'b0, o, d, q, nk);
		chk("write ack", 16'h0, 16'(nk));
	endtask
	task automatic rd(input logic [7:0] o, input logic [7:0] e);
		u_host.acc(7'h6d, 1'b1, o, 8'h00, q, nk);
		chk("read ack", 16'h8, 16'(nk));
		chk("read data", 16'(e), 16'(q));
	endtask
	task automatic end_of_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog, well past the expected run of about 11k cycles
	initial
	begin
		#4_000_000;
		n_mismatch++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence; strap high through reset sets address low bit
	// ----------------------------------------
	initial
	begin
		cyc(10);
		rst = 1'b0;
		cyc(10);
		slp_i = 1'b0;
		cyc(5);
		chk("error", 16'h1, 16'(err));
		u_host.acc(7'h6c, 1'b0, OFS_ANALOG_CONFIG, 8'h80, q, nk);
		chk("wrong addr", 16'h7, 16'(nk));
		chk("parallel_bridge_mode", 16'h0, 16'(pb));
		rd(OFS_ANALOG_CONFIG, RST_ANALOG_CONFIG);
		rd(8'h07, 8'h00);
		wr(OFS_ANALOG_CONFIG, 8'h8e);
		cyc(3);
		chk("parallel_bridge_mode", 16'h1, 16'(pb));
		chk("gain", 16'h3, 16'(ag));
		rd(OFS_ANALOG_CONFIG, 8'h8e);
		foreach (fm[i])
		begin
			wr(OFS_DIGITAL_CTL, 8'h18 | 8'(fm[i]));
			u_host.i2s = (fm[i] == FMT_I2S);
			wv(3);
			// Bridge on with channel bit set: both outputs carry the right word
			chk("left", fm[i] == 3'h0 ? u_host.rw[15:0] : u_host.rw[31:16], al);
			chk("right", fm[i] == 3'h0 ? u_host.rw[15:0] : u_host.rw[31:16], ar);
			chk("ds", 16'h1, 16'(ds));
			chk("error", 16'h0, 16'(err));
			chk("enable", 16'h1, 16'(en));
		end
		wr(OFS_ANALOG_CONFIG, 8'h0c);
		wr(OFS_DIGITAL_CTL, 8'h15);
		u_host.i2s = 1'b0;
		u_host.gap = 16000;
		wv(3);
		chk("error", 16'h0, 16'(err));
		chk("left", u_host.lw[31:16], al);
		chk("right", u_host.rw[31:16], ar);
		chk("parallel_bridge_mode", 16'h0, 16'(pb));
		u_host.nb = 20;
		cyc(FRAME_TO_CYC + 50);
		chk("error", 16'h1, 16'(err));
		chk("enable", 16'h0, 16'(en));
		u_host.nb = 32;
		u_host.gap = 0;
		wr(OFS_DIGITAL_CTL, 8'h2d);
		wv(3);
		chk("boost", 16'h2, 16'(bst));
		slp_i = 1'b1;
		cyc(5);
		chk("sleep", 16'h1, 16'(slp));
		sdn = 1'b0;
		cyc(5);
		chk("enable", 16'h0, 16'(en));
		sdn = 1'b1;
		slp_i = 1'b0;
		cyc(5);
		chk("enable", 16'h1, 16'(en));
		gs = 2'h1;
		cyc(6);
		chk("hw parallel_bridge_mode", 16'h1, 16'(pb));
		chk("hw gain", 16'h1, 16'(ag));
		chk("hw boost", 16'(BOOST_HW), 16'(bst));
		chk("hw ds", 16'h0, 16'(ds));
		u_host.scl_o = 1'b0;
		cyc(6);
		chk("hw parallel_bridge_mode", 16'h0, 16'(pb));
		end_of_test();
	end
endmodule
